// ---- rtl/trig_pkg.sv ----
// Constants and types for the probe trigger comparator.
// Functional notes
// - The trigger works only in comparator or comparator-or-external mode.
// - Non-participating probes are don't-care and never affect the result.
// - Each comparator offers ==, !=, <, <=, > and >=.
// - The operator compares the probe value with the programmed value.
// - Results combine by AND, OR, NAND or NOR over participating probes.
// - The radix (bin, hex, oct, unsigned, signed) sets how value bits map.
// - Binary form matches each bit as zero, one or don't-care.
// - Binary form matches a bit on rising, falling or either transition.
// - A no-transition bit matches when it equals its previous sample.
// - A hex don't-care digit masks the four bits it covers.
// - An octal don't-care digit masks the three bits it covers.
// - Decimal values compare as whole unsigned or signed numbers.
// - Probes sharing a port allow only AND and NAND combining.
// - Probes derived from constants never take part in triggering.
`default_nettype none
package trig_pkg;
  localparam int MAX_W      = 32;
  localparam int MAX_PROBES = 16;
  localparam int ADDR_W     = 12;

  localparam logic [11:0] CONFIG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] HIT_OFS    = 12'h008;
  localparam logic [3:0]  PROBE_PAGE = 4'h1;
  localparam logic [3:0]  P_CTRL     = 4'h0;
  localparam logic [3:0]  P_VALUE    = 4'h4;
  localparam logic [3:0]  P_CARE     = 4'h8;
  localparam logic [3:0]  P_EDGE     = 4'hC;

  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_COND_LSB   = 2;
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_RADIX_LSB = 3;
  localparam int CTRL_PART_BIT  = 8;
  localparam int CTRL_SHARE_BIT = 9;
  localparam int CTRL_CONST_BIT = 10;
  localparam int ST_TRIG_BIT    = 0;
  localparam int ST_ILLEGAL_BIT = 1;
  localparam int ST_EXT_BIT     = 2;
  localparam int ST_HITS_LSB    = 16;
  localparam int HIT_BIT        = 0;

  localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    OP_EQ = 3'h0, OP_NE = 3'h1, OP_LT = 3'h2,
    OP_LE = 3'h3, OP_GT = 3'h4, OP_GE = 3'h5
  } op_type;

  typedef enum logic [2:0] {
    RADIX_BIN = 3'h0, RADIX_HEX = 3'h1, RADIX_OCT = 3'h2,
    RADIX_UDEC = 3'h3, RADIX_SDEC = 3'h4
  } radix_type;

  typedef enum logic [1:0] {
    COND_AND = 2'h0, COND_OR = 2'h1, COND_NAND = 2'h2, COND_NOR = 2'h3
  } cond_type;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_COMPARATOR_ONLY = 2'h1,
    COMPARATOR_OR_EXTERNAL_TRIGGER_MODE = 2'h2,
    MODE_OTHER = 2'h3
  } mode_type;

  typedef struct packed {
    op_type      op;
    radix_type   radix;
    logic        participate;
    logic        shared;
    logic        constant;
    logic [31:0] value;
    logic [31:0] care;
    logic [31:0] edge_en;
  } probe_cfg_type;
endpackage : trig_pkg
`default_nettype wire

// ---- rtl/probe_comparator.sv ----
// One probe comparator: level, masked and transition matching.
`timescale 1ns/1ns
`default_nettype none
module probe_comparator #(
  parameter int PROBE_W = 32
) (
  input  wire trig_pkg::probe_cfg_type cfg_in,  // Probe settings
  input  wire logic [31:0]             cur_in,  // Current sample
  input  wire logic [31:0]             prev_in, // Previous sample
  output logic                         hit_out  // Comparator true
);
  import trig_pkg::*;

  if (PROBE_W < 1 || PROBE_W > MAX_W) begin : g_bad_width
    $error("probe_comparator: unsupported PROBE_W");
  end

  localparam int          SH    = MAX_W - PROBE_W;
  localparam logic [31:0] WMASK = 32'hFFFF_FFFF >> SH;

  // A care bit covers one bit, a nibble or an octal digit by radix.
  function automatic logic [31:0] expand(logic [31:0] c, radix_type r);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < MAX_W; i++) begin
      unique case (r)
        RADIX_BIN:  m[i] = c[i];
        RADIX_HEX:  m[i] = c[i/4];
        RADIX_OCT:  m[i] = c[i/3];
        default:    m[i] = 1'b1;
      endcase
    end
    return m;
  endfunction

  logic [31:0] care, edges, lvl, a, b, rise, fall, chg, bad;
  logic        sgn, op_ok;

  always_comb begin
    care  = expand(cfg_in.care, cfg_in.radix) & WMASK;
    edges = (cfg_in.radix == RADIX_BIN) ? cfg_in.edge_en & WMASK : '0;
    lvl   = care & ~edges;
    // Shifting to the top keeps signed order at any probe width.
    a     = (cur_in & lvl) << SH;
    b     = (cfg_in.value & lvl) << SH;
    sgn   = (cfg_in.radix == RADIX_SDEC);
    unique case (cfg_in.op)
      OP_EQ:   op_ok = (a == b);
      OP_NE:   op_ok = (a != b);
      OP_LT:   op_ok = sgn ? ($signed(a) < $signed(b)) : (a < b);
      OP_LE:   op_ok = sgn ? ($signed(a) <= $signed(b)) : (a <= b);
      OP_GT:   op_ok = sgn ? ($signed(a) > $signed(b)) : (a > b);
      OP_GE:   op_ok = sgn ? ($signed(a) >= $signed(b)) : (a >= b);
      default: op_ok = 1'b0;
    endcase
    rise = cur_in & ~prev_in;
    fall = ~cur_in & prev_in;
    chg  = cur_in ^ prev_in;
    // Value/care pick R (11), F (01), either (10) or no change (00).
    bad  = edges & ((cfg_in.value & cfg_in.care & ~rise)
                  | (~cfg_in.value & cfg_in.care & ~fall)
                  | (cfg_in.value & ~cfg_in.care & ~chg)
                  | (~cfg_in.value & ~cfg_in.care & chg));
    hit_out = op_ok && (bad == '0);
  end
endmodule // probe_comparator
`default_nettype wire

// ---- rtl/trigger_combiner.sv ----
// Global combine of participating comparator results.
`timescale 1ns/1ns
`default_nettype none
module trigger_combiner #(
  parameter int NPROBE = 4
) (
  input  wire logic [NPROBE-1:0] hits_in, // Comparator results
  input  wire logic [NPROBE-1:0] part_in, // Participating probes
  input  wire trig_pkg::cond_type cond_in, // Combine function
  output logic                   cond_out // Combined condition
);
  import trig_pkg::*;

  if (NPROBE < 1 || NPROBE > MAX_PROBES) begin : g_bad_count
    $error("trigger_combiner: unsupported NPROBE");
  end

  // Non-participating results act as don't-care for every function.
  always_comb begin
    unique case (cond_in)
      COND_AND:  cond_out = &(hits_in | ~part_in);
      COND_OR:   cond_out = |(hits_in & part_in);
      COND_NAND: cond_out = |(~hits_in & part_in);
      COND_NOR:  cond_out = ~|(hits_in & part_in);
    endcase
  end
endmodule // trigger_combiner
`default_nettype wire

// ---- rtl/probe_trigger_comparator.sv ----
// Probe trigger comparator top with APB register slave.
`timescale 1ns/1ns
`default_nettype none
module probe_trigger_comparator #(
  parameter int NPROBE  = 4,
  parameter int PROBE_W = 32
) (
  input  wire logic                      clk_in,     // Sample clock
  input  wire logic                      arst_n_in,  // Async reset, low
  input  wire logic [trig_pkg::ADDR_W-1:0] paddr,    // APB address
  input  wire logic                      psel,       // APB select
  input  wire logic                      penable,    // APB enable
  input  wire logic                      pwrite,     // APB direction
  input  wire logic [31:0]               pwdata,     // APB write data
  output logic [31:0]                    prdata,     // APB read data
  output logic                           pready,     // APB ready
  output logic                           pslverr,    // APB error
  input  wire logic [NPROBE*PROBE_W-1:0] probes_in,  // Probed nets
  input  wire logic                      external_trigger_input_in, // Pin
  output logic                           trigger_out // Trigger condition
);
  import trig_pkg::*;

  // Sizes beyond the package limits would overrun the 32-bit fields.
  if (NPROBE < 1 || NPROBE > MAX_PROBES
      || PROBE_W < 1 || PROBE_W > MAX_W) begin : g_bad_params
    $error("probe_trigger_comparator: unsupported NPROBE or PROBE_W");
  end

  // Configuration and state.
  mode_type      mode_q;
  cond_type      cond_q;
  probe_cfg_type cfg_q [NPROBE];
  logic [NPROBE*PROBE_W-1:0] prev_q;
  logic [NPROBE-1:0] hits_q, hit_w, part_vec, const_vec, share_vec;
  logic [NPROBE-1:0] eff_part;
  logic          comb_w, illegal, trig_q, trig_d, hit_q;
  logic          ext_meta_q, ext_sync_q;
  logic [31:0]   prdata_q, rd_d;
  logic          err_q, err_d;

  // APB decode helpers.
  function automatic logic is_probe(logic [ADDR_W-1:0] a);
    return (a[11:8] == PROBE_PAGE) && (32'(a[7:4]) < NPROBE);
  endfunction

  function automatic logic mapped(logic [ADDR_W-1:0] a);
    return (a == CONFIG_OFS) || (a == STATUS_OFS) || (a == HIT_OFS)
           || is_probe(a);
  endfunction

  logic setup, access, wr;
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign wr     = access && pwrite && mapped(paddr);

  // Global configuration.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= mode_type'(CONFIG_RESET[CFG_MODE_LSB +: 2]);
      cond_q <= cond_type'(CONFIG_RESET[CFG_COND_LSB +: 2]);
    end else if (wr && paddr == CONFIG_OFS) begin
      mode_q <= mode_type'(pwdata[CFG_MODE_LSB +: 2]);
      cond_q <= cond_type'(pwdata[CFG_COND_LSB +: 2]);
    end
  end

  // Per-probe settings; reset leaves every probe out of the trigger.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int p = 0; p < NPROBE; p++) begin
        cfg_q[p] <= '0;
      end
    end else if (wr && is_probe(paddr)) begin
      for (int p = 0; p < NPROBE; p++) begin
        if (32'(paddr[7:4]) == p) begin
          unique case (paddr[3:0])
            P_CTRL: begin
              cfg_q[p].op <= op_type'(pwdata[CTRL_OP_LSB +: 3]);
              cfg_q[p].radix <= radix_type'(pwdata[CTRL_RADIX_LSB +: 3]);
              cfg_q[p].participate <= pwdata[CTRL_PART_BIT];
              cfg_q[p].shared <= pwdata[CTRL_SHARE_BIT];
              cfg_q[p].constant <= pwdata[CTRL_CONST_BIT];
            end
            P_VALUE: cfg_q[p].value <= pwdata;
            P_CARE:  cfg_q[p].care <= pwdata;
            P_EDGE:  cfg_q[p].edge_en <= pwdata;
            default: cfg_q[p].value <= cfg_q[p].value;
          endcase
        end
      end
    end
  end

  // External trigger pin crosses into the sample clock.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_trigger_input_in;
      ext_sync_q <= ext_meta_q;
    end
  end

  // Previous sample feeds the transition qualifiers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= probes_in;
    end
  end

  for (genvar g = 0; g < NPROBE; g++) begin : g_cmp
    logic [31:0] cur, prv;
    assign cur = 32'(probes_in[g*PROBE_W +: PROBE_W]);
    assign prv = 32'(prev_q[g*PROBE_W +: PROBE_W]);
    assign part_vec[g]  = cfg_q[g].participate;
    assign const_vec[g] = cfg_q[g].constant;
    assign share_vec[g] = cfg_q[g].shared;
    probe_comparator #(.PROBE_W(PROBE_W)) u_cmp (
      .cfg_in  (cfg_q[g]),
      .cur_in  (cur),
      .prev_in (prv),
      .hit_out (hit_w[g])
    );
  end

  assign eff_part = part_vec & ~const_vec;
  // Shared-port comparators cannot serve OR or NOR.
  assign illegal = |(eff_part & share_vec)
                   && (cond_q == COND_OR || cond_q == COND_NOR);

  trigger_combiner #(.NPROBE(NPROBE)) u_comb (
    .hits_in  (hits_q),
    .part_in  (eff_part),
    .cond_in  (cond_q),
    .cond_out (comb_w)
  );

  always_comb begin
    unique case (mode_q)
      MODE_COMPARATOR_ONLY: trig_d = comb_w && !illegal;
      COMPARATOR_OR_EXTERNAL_TRIGGER_MODE:
        trig_d = (comb_w && !illegal) || ext_sync_q;
      default: trig_d = 1'b0;
    endcase
  end

  // Results are registered once per cycle, then combined.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hits_q <= '0;
      trig_q <= 1'b0;
    end else begin
      hits_q <= hit_w;
      trig_q <= trig_d;
    end
  end

  assign trigger_out = trig_q;

  // Sticky hit: a new trigger wins over a write-one clear.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hit_q <= 1'b0;
    end else if (trig_q) begin
      hit_q <= 1'b1;
    end else if (wr && paddr == HIT_OFS && pwdata[HIT_BIT]) begin
      hit_q <= 1'b0;
    end
  end

  // Read data is fetched in the setup cycle so it leaves a flop.
  always_comb begin
    rd_d  = '0;
    err_d = !mapped(paddr);
    if (paddr == CONFIG_OFS) begin
      rd_d[CFG_MODE_LSB +: 2] = mode_q;
      rd_d[CFG_COND_LSB +: 2] = cond_q;
    end else if (paddr == STATUS_OFS) begin
      rd_d[ST_TRIG_BIT]    = trig_q;
      rd_d[ST_ILLEGAL_BIT] = illegal;
      rd_d[ST_EXT_BIT]     = ext_sync_q;
      rd_d[ST_HITS_LSB +: NPROBE] = hits_q;
    end else if (paddr == HIT_OFS) begin
      rd_d[HIT_BIT] = hit_q;
    end else if (is_probe(paddr)) begin
      for (int p = 0; p < NPROBE; p++) begin
        if (32'(paddr[7:4]) == p) begin
          unique case (paddr[3:0])
            P_CTRL: begin
              rd_d[CTRL_OP_LSB +: 3]    = cfg_q[p].op;
              rd_d[CTRL_RADIX_LSB +: 3] = cfg_q[p].radix;
              rd_d[CTRL_PART_BIT]       = cfg_q[p].participate;
              rd_d[CTRL_SHARE_BIT]      = cfg_q[p].shared;
              rd_d[CTRL_CONST_BIT]      = cfg_q[p].constant;
            end
            P_VALUE: rd_d = cfg_q[p].value;
            P_CARE:  rd_d = cfg_q[p].care;
            P_EDGE:  rd_d = cfg_q[p].edge_en;
            default: err_d = 1'b1;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_d;
      err_q    <= err_d;
    end
  end

  assign prdata  = access ? prdata_q : '0;
  assign pslverr = access && err_q;

  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_mode_idle;
    (mode_q == MODE_OFF || mode_q == MODE_OTHER) |=> !trig_q;
  endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("trigger fired while comparator mode inactive");

  property p_ext_or;
    (mode_q == COMPARATOR_OR_EXTERNAL_TRIGGER_MODE && ext_sync_q)
      |=> trig_q;
  endproperty
  a_ext_or: assert property (p_ext_or)
    else $error("external trigger not ORed into trigger");

  property p_and_excl;
    (mode_q == MODE_COMPARATOR_ONLY && cond_q == COND_AND
     && &(hits_q | ~part_vec | const_vec)) |=> trig_q;
  endproperty
  a_and_excl: assert property (p_and_excl)
    else $error("excluded probe blocked AND trigger");

  property p_or_any;
    (mode_q == MODE_COMPARATOR_ONLY && cond_q == COND_OR && !illegal
     && |(hits_q & eff_part)) |=> trig_q;
  endproperty
  a_or_any: assert property (p_or_any)
    else $error("OR condition missed a true comparator");

  property p_nor_block;
    (cond_q == COND_NOR && |(hits_q & eff_part)
     && !(mode_q == COMPARATOR_OR_EXTERNAL_TRIGGER_MODE && ext_sync_q))
      |=> !trig_q;
  endproperty
  a_nor_block: assert property (p_nor_block)
    else $error("NOR condition true with a true comparator");

  property p_shared;
    (illegal && mode_q == MODE_COMPARATOR_ONLY) |=> !trig_q;
  endproperty
  a_shared: assert property (p_shared)
    else $error("OR or NOR used on a shared probe port");

  property p_prev;
    ##1 prev_q == $past(probes_in);
  endproperty
  a_prev: assert property (p_prev)
    else $error("previous sample register lags wrongly");

  property p_eq0;
    (cfg_q[0].op == OP_EQ && cfg_q[0].radix == RADIX_UDEC
     && probes_in[PROBE_W-1:0] == cfg_q[0].value[PROBE_W-1:0])
      |=> hits_q[0];
  endproperty
  a_eq0: assert property (p_eq0)
    else $error("equal compare missed on probe 0");

  property p_sticky;
    trig_q |=> hit_q;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sticky hit flag not set by trigger");

  property p_slverr;
    (setup && !mapped(paddr)) ##1 access |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not flagged");

  property p_c_and;
    cond_q == COND_AND && |eff_part && trig_q;
  endproperty
  c_and: cover property (p_c_and);

  property p_c_or;
    cond_q == COND_OR && trig_q;
  endproperty
  c_or: cover property (p_c_or);

  property p_c_ext;
    mode_q == COMPARATOR_OR_EXTERNAL_TRIGGER_MODE && ext_sync_q ##1 trig_q;
  endproperty
  c_ext: cover property (p_c_ext);
endmodule // probe_trigger_comparator
`default_nettype wire

// ---- verification/probe_source.sv ----
// Model of the user design nets that feed the probe inputs.
`timescale 1ns/1ns
`default_nettype none
module probe_source #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,    // Shared sample clock
  input  wire logic             arst_n_in, // Async reset, low
  input  wire logic [WIDTH-1:0] next_in,   // Value for the next cycle
  output logic      [WIDTH-1:0] probes_out // Probed net values
);
  // The nets are ordinary same-clock logic, so they change just after
  // each edge and are stable for the whole cycle the design samples.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      probes_out <= '0;
    end else begin
      probes_out <= next_in;
    end
  end
endmodule // probe_source
`default_nettype wire

// ---- verification/probe_trigger_comparator_bench.sv ----
// Self-checking bench for the probe trigger comparator.
`timescale 1ns/1ns
`default_nettype none
module probe_trigger_comparator_bench;
  import trig_pkg::*;
  localparam int NP = 2;
  localparam int W  = 8;
  logic            clk_in    = 1'b0;
  logic            arst_n_in = 1'b0;
  logic [11:0]     paddr     = 12'h000;
  logic            psel      = 1'b0;
  logic            penable   = 1'b0;
  logic            pwrite    = 1'b0;
  logic [31:0]     pwdata    = 32'h00000000;
  logic            ext       = 1'b0;
  logic [NP*W-1:0] next_val  = 16'h0000;
  logic [31:0]     seed      = 32'h23C300EC;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            trigger_out;
  wire  [NP*W-1:0] probes;
  logic [10:0]     ctrl [NP];
  logic [W-1:0]    val [NP];
  logic [W-1:0]    care [NP];
  logic [W-1:0]    edg [NP];
  logic [W-1:0]    h [5][NP];
  logic [1:0]      mode;
  logic [1:0]      cond;
  logic [2:0]      rad_v;
  logic [2:0]      op_v;
  logic [31:0]     rd;
  logic [31:0]     x;
  logic            err;
  int              n_mismatch = 0;
  int              samples_checked = 0;
  int              cycles = 0;

  always #2 clk_in = ~clk_in;

  probe_source #(.WIDTH(NP*W)) u_src (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .next_in(next_val),
    .probes_out(probes));

  probe_trigger_comparator #(.NPROBE(NP), .PROBE_W(W)) u_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .probes_in(probes),
    .external_trigger_input_in(ext), .trigger_out(trigger_out));

  // Eight shifts per call so successive draws are not plain shifts.
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 8; i++) begin
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    end
    return seed;
  endfunction

  function automatic logic hit_f(logic [10:0] c, logic [W-1:0] v, k, e,
                                 cur, prv);
    logic [W-1:0] m;
    logic [W-1:0] t;
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic         lv;
    logic         tr;
    int           r;
    r = int'(c[5:3]);
    tr = 1'b1;
    for (int i = 0; i < W; i++) begin
      m[i] = (r == 0) ? k[i] : (r == 1) ? k[i/4]
           : (r == 2) ? k[i/3] : 1'b1;
    end
    t = (r == 0) ? e : 8'h00;
    a = cur & m & ~t;
    b = v & m & ~t;
    // Flipping the sign bit turns a two's complement order into unsigned.
    if (r == 4) begin
      a[W-1] = ~a[W-1];
      b[W-1] = ~b[W-1];
    end
    case (c[2:0])
      3'h0: lv = (a == b);
      3'h1: lv = (a != b);
      3'h2: lv = (a < b);
      3'h3: lv = (a <= b);
      3'h4: lv = (a > b);
      default: lv = (a >= b);
    endcase
    for (int i = 0; i < W; i++) begin
      if (t[i]) begin
        case ({v[i], k[i]})
          2'b11: tr &= cur[i] & ~prv[i];
          2'b01: tr &= ~cur[i] & prv[i];
          2'b10: tr &= cur[i] ^ prv[i];
          default: tr &= ~(cur[i] ^ prv[i]);
        endcase
      end
    end
    return lv & tr;
  endfunction

  function automatic logic exp_f();
    logic any_t;
    logic all_t;
    logic ill;
    logic comp;
    logic hv;
    any_t = 1'b0;
    all_t = 1'b1;
    ill = 1'b0;
    for (int p = 0; p < NP; p++) begin
      if (ctrl[p][8] && !ctrl[p][10]) begin
        hv = hit_f(ctrl[p], val[p], care[p], edg[p], h[2][p], h[3][p]);
        any_t |= hv;
        all_t &= hv;
        ill |= ctrl[p][9];
      end
    end
    case (cond)
      2'h0: comp = all_t;
      2'h1: comp = any_t;
      2'h2: comp = !all_t;
      default: comp = !any_t;
    endcase
    if (cond[0] && ill) begin
      comp = 1'b0;
    end
    return ((mode == 2'h1 || mode == 2'h2) && comp)
           || (mode == 2'h2 && ext);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    apb(1'b0, CONFIG_OFS, 32'h00000000);
    check(rd, CONFIG_RESET, "config reset");
    apb(1'b0, 12'h100, 32'h00000000);
    check(rd, 32'h00000000, "probe ctrl reset");
    apb(1'b0, 12'h120, 32'h00000000);
    check({31'h0, err}, 32'h00000001, "unmapped error");
    for (int r = 0; r < 48; r++) begin
      x = rnd();
      @(posedge clk_in);
      ext <= x[5];
      mode = (r % 9 == 8) ? 2'h0 : (r % 9 == 7) ? 2'h3 : 2'(1 + x[0]);
      cond = 2'(r % 4);
      for (int p = 0; p < NP; p++) begin
        x = rnd();
        op_v = 3'((p == 0) ? r % 6 : x % 6);
        rad_v = 3'((p == 0) ? r % 5 : x[15:8] % 5);
        ctrl[p] = {x[20] & x[21] & ~x[22], x[22] & x[23], x[24] | (p == 0),
                   2'b00, rad_v, op_v};
        x = rnd();
        val[p] = x[7:0];
        care[p] = x[15:8];
        edg[p] = x[23:16] & x[31:24];
        apb(1'b1, 12'(256 + p * 16), {21'h0, ctrl[p]});
        apb(1'b1, 12'(260 + p * 16), {24'h0, val[p]});
        apb(1'b1, 12'(264 + p * 16), {24'h0, care[p]});
        apb(1'b1, 12'(268 + p * 16), {24'h0, edg[p]});
      end
      apb(1'b1, CONFIG_OFS, {28'h0, cond, mode});
      apb(1'b0, CONFIG_OFS, 32'h00000000);
      check(rd, {28'h0, cond, mode}, "config readback");
      for (int k = 0; k < 40; k++) begin
        @(posedge clk_in);
        for (int p = 0; p < NP; p++) begin
          x = rnd();
          next_val[p*W +: W] <= x[2] ? x[15:8] : val[p] ^ {6'h00, x[1:0]};
        end
        #1;
        for (int j = 4; j > 0; j--) begin
          h[j] = h[j-1];
        end
        for (int p = 0; p < NP; p++) begin
          h[0][p] = probes[p*W +: W];
        end
        if (k >= 8) begin
          check(32'(trigger_out), 32'(exp_f()), "trigger");
        end
      end
    end
    // Sticky hit: cleared while idle, then set through the external pin.
    apb(1'b1, CONFIG_OFS, 32'h00000000);
    apb(1'b1, HIT_OFS, 32'h00000001);
    apb(1'b0, HIT_OFS, 32'h00000000);
    check(rd, 32'h00000000, "hit cleared");
    ext <= 1'b1;
    apb(1'b1, CONFIG_OFS, 32'h00000002);
    repeat (4) @(posedge clk_in);
    apb(1'b0, HIT_OFS, 32'h00000000);
    check(rd, 32'h00000001, "hit sticky");
    apb(1'b0, STATUS_OFS, 32'h00000000);
    check(rd & 32'h00000007, 32'h00000005, "status");
    wrap_up();
  end
endmodule // probe_trigger_comparator_bench
`default_nettype wire
